// >>> design/exv_pkg.sv
// Package of constants and types for the exception vectoring unit
package exv_pkg;
	localparam int unsigned EXV_AW = 32; // Address width
	localparam int unsigned EXV_DW = 32; // Data width
	localparam logic [7:0] EXV_VEC_RESET_PC = 8'h00; // Initial PC vector
	localparam logic [7:0] EXV_VEC_RESET_SP = 8'h01; // Initial SP vector
	localparam logic [7:0] EXV_VEC_GEN_ILL = 8'h04; // General illegal instruction
	localparam logic [7:0] EXV_VEC_SLOT_ILL = 8'h06; // Slot illegal instruction
	localparam logic [7:0] EXV_VEC_CPU_AERR = 8'h09; // CPU address error
	localparam logic [7:0] EXV_VEC_DMA_AERR = 8'h0a; // DMA address error
	localparam logic [7:0] EXV_VEC_NMI = 8'h0c; // Nonmaskable interrupt
	localparam logic [7:0] EXV_VEC_UBRK = 8'h0d; // User break
	localparam logic [7:0] EXV_VEC_TRAP_LO = 8'h20; // First trap user vector
	localparam logic [7:0] EXV_VEC_TRAP_HI = 8'h3f; // Last trap user vector
	localparam logic [5:0] EXV_TRAP_MASK = 6'h1f; // Trap number bits within user range
	localparam int unsigned EXV_VEC_SHIFT = 2; // Vector number times four
	localparam logic [31:0] EXV_WORD_BYTES = 32'h0000_0004; // Stack push step
	localparam logic [31:0] EXV_VBR_RESET = 32'h0000_0000; // Table base after reset
	localparam logic [3:0] EXV_IMASK_RESET = 4'hf; // Interrupt mask after reset
	localparam int unsigned EXV_IMASK_LSB = 4; // Mask field position in status word
	localparam logic [31:0] EXV_SR_RESET = 32'h0000_00f0; // Status word after reset
	localparam logic [1:0] EXV_SZ_BYTE = 2'h0; // Access sizes
	localparam logic [1:0] EXV_SZ_WORD = 2'h1;
	localparam logic [1:0] EXV_SZ_LONG = 2'h2;

	// Sources of a non-reset exception request
	typedef enum logic [2:0] {
		EXV_SRC_CPU_AERR = 3'h0,
		EXV_SRC_DMA_AERR = 3'h1,
		EXV_SRC_NMI = 3'h2,
		EXV_SRC_UBRK = 3'h3,
		EXV_SRC_GEN_ILL = 3'h4,
		EXV_SRC_SLOT_ILL = 3'h5,
		EXV_SRC_TRAP = 3'h6,
		EXV_SRC_IRQ = 3'h7
	} exv_src_e;

	// Sequencer states, Gray along the reset path and from EXV_ST_RUN to EXV_ST_FETCH_VEC
	typedef enum logic [2:0] {
		EXV_ST_RESET = 3'b000,
		EXV_ST_FETCH_PC = 3'b001,
		EXV_ST_FETCH_SP = 3'b011,
		EXV_ST_RUN = 3'b010,
		EXV_ST_PUSH_SR = 3'b110,
		EXV_ST_PUSH_PC = 3'b111,
		EXV_ST_FETCH_VEC = 3'b101
	} exv_state_e;
endpackage : exv_pkg

// >>> design/exv_acc_if.sv
// Interface carrying one bus access to the address checker
`timescale 1ns/1ps
interface exv_acc_if;
	import exv_pkg::*;
	logic valid; // Access in progress
	logic fetch; // Instruction fetch
	logic [EXV_AW-1:0] addr; // Byte address
	logic [1:0] size; // Access size
	logic periph; // Target in peripheral space
	logic external; // Target in external space
	logic err; // Access is an address error
	modport src (output valid, fetch, addr, size, periph, external, input err);
	modport chk (input valid, fetch, addr, size, periph, external, output err);
endinterface : exv_acc_if

// >>> design/exv_addr_check.sv
// Address error check for one bus master's access
`timescale 1ns/1ps
module exv_addr_check (
	exv_acc_if.chk acc, // Access under check
	input wire logic single_chip // Single-chip operating mode
);
	import exv_pkg::*;

	// Classify the access
	always_comb begin
		acc.err = 1'b0;
		if (acc.valid) begin
			if (single_chip && acc.external) begin
				acc.err = 1'b1;
			end else if (acc.fetch) begin
				acc.err = acc.addr[0] | acc.periph;
			end else if (acc.periph) begin
				acc.err = 1'b0;
			end else if (acc.size == EXV_SZ_WORD) begin
				acc.err = acc.addr[0];
			end else if (acc.size == EXV_SZ_LONG) begin
				acc.err = |acc.addr[1:0];
			end
		end
	end
endmodule : exv_addr_check

// >>> design/exv_unit.sv
// Exception vectoring, power-on reset entry and address error entry
//
// How it works
// - Reset vector address is number times four
// - Other vectors add table base to number*4
// - Fixed vector numbers for each source except trap and interrupt, which take theirs from exc_vec
// - Trap vectors occupy numbers 32 to 63
// - Handler address read as one table word
// - Stay in reset while clear pin low
// - Reset initialises CPU state and registers
// - After release fetch PC then SP
// - Reset clears table base, sets mask ones
// - Load PC and SP, then run
// - Odd instruction fetch is an error
// - Fetch from peripheral space is an error
// - Single-chip external access is an error
// - Odd word data access is an error
// - Misaligned longword data access is an error
// - Peripheral data accesses never flag errors
// - Error entry waits for instruction end
// - Push status word, then next PC
// - Fetch handler, jump without delay slot
// - Stack general register is the pointer
// - Error entry keeps interrupt mask unchanged
`timescale 1ns/1ps
module exv_unit (
	input wire logic clk, // 40 MHz clock
	input wire logic rst_n, // Power-on clear pin, active low
	input wire logic single_chip, // Single-chip operating mode
	input wire logic cpu_acc_valid, // CPU access valid
	input wire logic cpu_acc_fetch, // CPU access is a fetch
	input wire logic [exv_pkg::EXV_AW-1:0] cpu_acc_addr, // CPU access address
	input wire logic [1:0] cpu_acc_size, // CPU access size
	input wire logic cpu_acc_periph, // CPU access in peripheral space
	input wire logic cpu_acc_external, // CPU access in external space
	input wire logic dma_acc_valid, // DMA access valid
	input wire logic [exv_pkg::EXV_AW-1:0] dma_acc_addr, // DMA access address
	input wire logic [1:0] dma_acc_size, // DMA access size
	input wire logic dma_acc_periph, // DMA access in peripheral space
	input wire logic dma_acc_external, // DMA access in external space
	input wire logic insn_done, // Current instruction completes
	input wire logic [exv_pkg::EXV_AW-1:0] next_pc, // Address after last executed one
	input wire logic [exv_pkg::EXV_DW-1:0] status_word_in, // Live status word
	input wire logic [exv_pkg::EXV_DW-1:0] stack_gpr_in, // Live stack register
	input wire logic exc_req, // Other exception request pulse
	input wire exv_pkg::exv_src_e exc_src, // Source of that request
	input wire logic [7:0] exc_vec, // Trap or interrupt vector number
	input wire logic [exv_pkg::EXV_DW-1:0] vbr_in, // Live table base register
	output logic mem_req, // Memory request
	output logic mem_we, // Memory write
	output logic [exv_pkg::EXV_AW-1:0] mem_addr, // Memory address
	output logic [exv_pkg::EXV_DW-1:0] mem_wdata, // Memory write data
	input wire logic [exv_pkg::EXV_DW-1:0] mem_rdata, // Memory read data
	input wire logic mem_ack, // Memory access done
	output logic cpu_hold, // CPU stalled by the sequencer
	output logic periph_reset, // Peripheral registers held at reset values
	output logic load_pc, // Pulse: take new_pc
	output logic [exv_pkg::EXV_AW-1:0] new_pc, // PC to start from
	output logic load_sp, // Pulse: take new_sp
	output logic [exv_pkg::EXV_DW-1:0] new_sp, // New stack register value
	output logic load_vbr, // Pulse: take new_vbr
	output logic [exv_pkg::EXV_DW-1:0] new_vbr, // New table base
	output logic load_sr, // Pulse: take new_sr
	output logic [exv_pkg::EXV_DW-1:0] new_sr, // New status word
	output logic cpu_aerr_seen, // Pulse: CPU address error detected
	output logic dma_aerr_seen // Pulse: DMA address error detected
);
	import exv_pkg::*;

	exv_acc_if cpu_acc (); // CPU access to check
	exv_acc_if dma_acc (); // DMA access to check

	exv_state_e state_q, state_d; // Sequencer state
	logic [EXV_AW-1:0] addr_q, addr_d; // Current bus address
	logic [EXV_DW-1:0] wdata_q, wdata_d; // Current write data
	logic [EXV_DW-1:0] sp_q, sp_d; // Working stack pointer
	logic [EXV_AW-1:0] pc_q, pc_d; // Captured return PC
	logic [EXV_AW-1:0] vaddr_q, vaddr_d; // Handler vector address
	logic [EXV_DW-1:0] init_pc_q, init_pc_d; // Fetched initial PC
	logic cpu_pend_q, cpu_pend_d; // CPU address error pending
	logic dma_pend_q, dma_pend_d; // DMA address error pending
	logic [7:0] vnum; // Vector number of the chosen source
	logic ld_pc_d, ld_sp_d, ld_vbr_d, ld_sr_d; // Next load strobes
	logic ld_pc_q, ld_sp_q, ld_vbr_q, ld_sr_q; // Registered load strobes
	logic [EXV_DW-1:0] nsr_d, nsr_q; // Next status word
	logic [EXV_DW-1:0] nsp_d, nsp_q; // Next stack value
	logic [EXV_AW-1:0] npc_d, npc_q; // Next PC

	// Route ports into the checkers
	assign cpu_acc.valid = cpu_acc_valid;
	assign cpu_acc.fetch = cpu_acc_fetch;
	assign cpu_acc.addr = cpu_acc_addr;
	assign cpu_acc.size = cpu_acc_size;
	assign cpu_acc.periph = cpu_acc_periph;
	assign cpu_acc.external = cpu_acc_external;
	assign dma_acc.valid = dma_acc_valid;
	assign dma_acc.fetch = 1'b0;
	assign dma_acc.addr = dma_acc_addr;
	assign dma_acc.size = dma_acc_size;
	assign dma_acc.periph = dma_acc_periph;
	assign dma_acc.external = dma_acc_external;

	exv_addr_check u_cpu_chk (
		.acc(cpu_acc),
		.single_chip(single_chip)
	);

	exv_addr_check u_dma_chk (
		.acc(dma_acc),
		.single_chip(single_chip)
	);

	// Vector number for a pending or just detected request
	always_comb begin
		if (cpu_pend_q || cpu_acc.err) begin
			vnum = EXV_VEC_CPU_AERR;
		end else if (dma_pend_q || dma_acc.err) begin
			vnum = EXV_VEC_DMA_AERR;
		end else begin
			case (exc_src)
				EXV_SRC_NMI: vnum = EXV_VEC_NMI;
				EXV_SRC_UBRK: vnum = EXV_VEC_UBRK;
				EXV_SRC_GEN_ILL: vnum = EXV_VEC_GEN_ILL;
				EXV_SRC_SLOT_ILL: vnum = EXV_VEC_SLOT_ILL;
				EXV_SRC_TRAP: vnum = EXV_VEC_TRAP_LO | {2'h0, exc_vec[5:0] & EXV_TRAP_MASK};
				EXV_SRC_CPU_AERR: vnum = EXV_VEC_CPU_AERR;
				EXV_SRC_DMA_AERR: vnum = EXV_VEC_DMA_AERR;
				default: vnum = exc_vec; // Interrupt vector from controller
			endcase
		end
	end

	// Sequencer next state
	always_comb begin
		state_d = state_q;
		addr_d = addr_q;
		wdata_d = wdata_q;
		sp_d = sp_q;
		pc_d = pc_q;
		vaddr_d = vaddr_q;
		init_pc_d = init_pc_q;
		ld_pc_d = 1'b0;
		ld_sp_d = 1'b0;
		ld_vbr_d = 1'b0;
		ld_sr_d = 1'b0;
		nsr_d = nsr_q;
		nsp_d = nsp_q;
		npc_d = npc_q;
		// Sticky pending errors, a new detection wins over the clear
		cpu_pend_d = cpu_pend_q | cpu_acc.err;
		dma_pend_d = dma_pend_q | dma_acc.err;
		case (state_q)
			EXV_ST_RESET: begin
				// First cycle after release, fetch initial PC
				state_d = EXV_ST_FETCH_PC;
				addr_d = {22'h0, EXV_VEC_RESET_PC, 2'h0};
			end
			EXV_ST_FETCH_PC: begin
				if (mem_ack) begin
					init_pc_d = mem_rdata;
					addr_d = {22'h0, EXV_VEC_RESET_SP, 2'h0};
					state_d = EXV_ST_FETCH_SP;
				end
			end
			EXV_ST_FETCH_SP: begin
				if (mem_ack) begin
					ld_pc_d = 1'b1;
					npc_d = init_pc_q;
					ld_sp_d = 1'b1;
					nsp_d = mem_rdata;
					ld_vbr_d = 1'b1;
					nsr_d = EXV_SR_RESET;
					ld_sr_d = 1'b1;
					state_d = EXV_ST_RUN;
				end
			end
			EXV_ST_RUN: begin
				// Take an exception only at instruction end
				if (insn_done && (cpu_pend_d || dma_pend_d || exc_req)) begin
					vaddr_d = vbr_in + {22'h0, vnum, 2'h0};
					pc_d = next_pc;
					sp_d = stack_gpr_in - EXV_WORD_BYTES;
					addr_d = stack_gpr_in - EXV_WORD_BYTES;
					wdata_d = status_word_in;
					// Retire the serviced error; a fresh detection stays pending
					if (cpu_pend_q) begin
						cpu_pend_d = cpu_acc.err;
					end else if (cpu_acc.err) begin
						cpu_pend_d = 1'b0; // Serviced in its own cycle
					end else if (dma_pend_q) begin
						dma_pend_d = dma_acc.err;
					end else if (dma_acc.err) begin
						dma_pend_d = 1'b0; // Serviced in its own cycle
					end
					state_d = EXV_ST_PUSH_SR;
				end
			end
			EXV_ST_PUSH_SR: begin
				if (mem_ack) begin
					sp_d = sp_q - EXV_WORD_BYTES;
					addr_d = sp_q - EXV_WORD_BYTES;
					wdata_d = pc_q;
					state_d = EXV_ST_PUSH_PC;
				end
			end
			EXV_ST_PUSH_PC: begin
				if (mem_ack) begin
					addr_d = vaddr_q;
					state_d = EXV_ST_FETCH_VEC;
				end
			end
			EXV_ST_FETCH_VEC: begin
				if (mem_ack) begin
					ld_pc_d = 1'b1;
					npc_d = mem_rdata;
					ld_sp_d = 1'b1;
					nsp_d = sp_q;
					state_d = EXV_ST_RUN;
				end
			end
			default: state_d = EXV_ST_RESET;
		endcase
	end

	// Sequencer registers; reset pin holds everything at reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= EXV_ST_RESET;
			addr_q <= '0;
			wdata_q <= '0;
			sp_q <= '0;
			pc_q <= '0;
			vaddr_q <= '0;
			init_pc_q <= '0;
			cpu_pend_q <= 1'b0;
			dma_pend_q <= 1'b0;
			ld_pc_q <= 1'b0;
			ld_sp_q <= 1'b0;
			ld_vbr_q <= 1'b0;
			ld_sr_q <= 1'b0;
			nsr_q <= EXV_SR_RESET;
			nsp_q <= '0;
			npc_q <= '0;
		end else begin
			state_q <= state_d;
			addr_q <= addr_d;
			wdata_q <= wdata_d;
			sp_q <= sp_d;
			pc_q <= pc_d;
			vaddr_q <= vaddr_d;
			init_pc_q <= init_pc_d;
			cpu_pend_q <= cpu_pend_d;
			dma_pend_q <= dma_pend_d;
			ld_pc_q <= ld_pc_d;
			ld_sp_q <= ld_sp_d;
			ld_vbr_q <= ld_vbr_d;
			ld_sr_q <= ld_sr_d;
			nsr_q <= nsr_d;
			nsp_q <= nsp_d;
			npc_q <= npc_d;
		end
	end

	// Bus and load outputs
	always_comb begin
		mem_req = (state_q == EXV_ST_FETCH_PC) || (state_q == EXV_ST_FETCH_SP) ||
			(state_q == EXV_ST_PUSH_SR) || (state_q == EXV_ST_PUSH_PC) ||
			(state_q == EXV_ST_FETCH_VEC);
		mem_we = (state_q == EXV_ST_PUSH_SR) || (state_q == EXV_ST_PUSH_PC);
		cpu_hold = (state_q != EXV_ST_RUN);
	end

	assign mem_addr = addr_q;
	assign mem_wdata = wdata_q;
	assign periph_reset = (state_q == EXV_ST_RESET);
	assign load_pc = ld_pc_q;
	assign new_pc = npc_q;
	assign load_sp = ld_sp_q;
	assign new_sp = nsp_q;
	assign load_vbr = ld_vbr_q;
	assign new_vbr = EXV_VBR_RESET;
	assign load_sr = ld_sr_q;
	assign new_sr = nsr_q;
	assign cpu_aerr_seen = cpu_acc.err;
	assign dma_aerr_seen = dma_acc.err;
endmodule : exv_unit

// >>> testbench/exv_unit_props.sv
// Checker of reset entry, address error flags and exception entry
`timescale 1ns/1ps
module exv_unit_props
	import exv_pkg::*;
(
	input wire logic clk, // Clock
	input wire logic rst_n, // Reset pin
	input wire logic cpu_acc_valid, // CPU access
	input wire logic cpu_acc_fetch, // Fetch
	input wire logic [31:0] cpu_acc_addr, // Address
	input wire logic cpu_acc_periph, // Peripheral
	input wire logic dma_acc_valid, // DMA access
	input wire logic [31:0] dma_acc_addr, // Address
	input wire logic [1:0] dma_acc_size, // Size
	input wire logic dma_acc_periph, // Peripheral
	input wire logic dma_acc_external, // External
	input wire logic insn_done, // Instruction end
	input wire logic [31:0] status_word_in, // Status word
	input wire logic [31:0] stack_gpr_in, // Stack register
	input wire logic mem_req, // Request
	input wire logic mem_we, // Write
	input wire logic [31:0] mem_addr, // Address
	input wire logic [31:0] mem_wdata, // Write data
	input wire logic mem_ack, // Done
	input wire logic cpu_hold, // Stall
	input wire logic load_pc, // PC load
	input wire logic load_sp, // SP load
	input wire logic load_vbr, // Base load
	input wire logic [31:0] new_vbr, // New base
	input wire logic load_sr, // SR load
	input wire logic [31:0] new_sr, // New status
	input wire logic cpu_aerr_seen, // CPU error
	input wire logic dma_aerr_seen // DMA error
);
	// One clock domain, reset pin as disable
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	AST_RESET_PC_FETCH: assert property ($rose(rst_n) |=> mem_req && !mem_we && mem_addr == 32'h0)
		else $error("first fetch after reset not at vector zero");
	AST_RESET_DONE: assert property ($rose(rst_n) |-> ##[1:40] load_vbr)
		else $error("reset handling did not finish");
	AST_RESET_LOADS: assert property (load_vbr |-> load_pc && load_sp && load_sr && new_vbr == 32'h0 && new_sr[7:4] == 4'hf)
		else $error("reset loads wrong");
	AST_MASK_KEPT: assert property (load_pc && !load_vbr |-> !load_sr)
		else $error("status word loaded on entry");
	AST_ODD_FETCH: assert property (cpu_acc_valid && cpu_acc_fetch && cpu_acc_addr[0] |-> cpu_aerr_seen)
		else $error("odd fetch not flagged");
	AST_PERIPH_FETCH: assert property (cpu_acc_valid && cpu_acc_fetch && cpu_acc_periph |-> cpu_aerr_seen)
		else $error("peripheral fetch not flagged");
	AST_LONG_ALIGN: assert property (dma_acc_valid && !dma_acc_periph && !dma_acc_external && dma_acc_size == EXV_SZ_LONG |-> dma_aerr_seen == (dma_acc_addr[1:0] != 2'h0))
		else $error("longword alignment flag wrong");
	AST_PERIPH_DATA: assert property (dma_acc_valid && dma_acc_periph |-> !dma_aerr_seen)
		else $error("peripheral data access flagged");
	AST_PUSH_SR: assert property ($rose(mem_req && mem_we) |-> mem_addr == stack_gpr_in - EXV_WORD_BYTES && mem_wdata == status_word_in)
		else $error("first push wrong");
	AST_DEFER: assert property (!cpu_hold && !insn_done |=> !mem_req)
		else $error("entry before instruction end");

	// Main scenarios reached
	cover property (load_vbr);
	cover property (mem_req && mem_we && mem_ack);
	cover property (dma_aerr_seen);
endmodule : exv_unit_props

bind exv_unit exv_unit_props props_u (.clk, .rst_n, .cpu_acc_valid, .cpu_acc_fetch, .cpu_acc_addr,
	.cpu_acc_periph, .dma_acc_valid, .dma_acc_addr, .dma_acc_size, .dma_acc_periph,
	.dma_acc_external, .insn_done, .status_word_in, .stack_gpr_in, .mem_req, .mem_we, .mem_addr,
	.mem_wdata, .mem_ack, .cpu_hold, .load_pc, .load_sp, .load_vbr, .new_vbr, .load_sr, .new_sr,
	.cpu_aerr_seen, .dma_aerr_seen);

// >>> testbench/exv_mem_model.sv
// System memory holding vector table and stack
`timescale 1ns/1ps
module exv_mem_model (
	input wire logic clk, // Clock
	input wire logic rst_n, // Reset, active low
	input wire logic [3:0] lat, // Wait cycles before ack
	input wire logic mem_req, // Request
	input wire logic mem_we, // Write
	input wire logic [31:0] mem_addr, // Address
	input wire logic [31:0] mem_wdata, // Write data
	output logic [31:0] mem_rdata, // Read data
	output logic mem_ack // Done
);
	logic [3:0] cnt_q; // Cycles waited
	logic [31:0] wa [2]; // Written addresses
	logic [31:0] wd [2]; // Written data
	logic wn; // Next write slot

	// Ack after lat waits; zero answers at once
	assign mem_ack = mem_req && (cnt_q >= lat);
	// One word per entry; inverted when not answering
	assign mem_rdata = mem_ack ? (32'ha500_0000 ^ mem_addr) : ~(32'ha500_0000 ^ mem_addr);

	// Wait counter and write log
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 4'h0;
			wn <= 1'b0;
		end else if (mem_ack) begin
			cnt_q <= 4'h0;
			if (mem_we) begin
				wa[wn] <= mem_addr;
				wd[wn] <= mem_wdata;
				wn <= ~wn;
			end
		end else if (mem_req) begin
			cnt_q <= cnt_q + 4'h1;
		end
	end
endmodule : exv_mem_model

// >>> testbench/test_cpu_exception_vectoring_reset_addr_err.sv
// Testbench of the exception vectoring unit
`timescale 1ns/1ps
`define CHK(nm, ex, ac) begin n_checks++; if ((ac) !== (ex)) begin n_errors++; $display("Error %s: expected %h seen %h", nm, ex, ac); end end
module test_cpu_exception_vectoring_reset_addr_err;
	import exv_pkg::*;
	logic clk, rst_n, single_chip, insn_done, exc_req, mem_req, mem_we, mem_ack;
	logic cpu_acc_valid, cpu_acc_fetch, cpu_acc_periph, cpu_acc_external, cpu_hold;
	logic dma_acc_valid, dma_acc_periph, dma_acc_external, periph_reset;
	logic load_pc, load_sp, load_vbr, load_sr, cpu_aerr_seen, dma_aerr_seen;
	logic [31:0] cpu_acc_addr, dma_acc_addr, next_pc, status_word_in, stack_gpr_in, vbr_in;
	logic [31:0] mem_addr, mem_wdata, mem_rdata, new_pc, new_sp, new_vbr, new_sr;
	logic [1:0] cpu_acc_size, dma_acc_size;
	logic [7:0] exc_vec;
	logic [3:0] lat;
	exv_src_e exc_src;
	int n_errors = 0;
	int n_checks = 0;

	exv_unit dut_u (.clk, .rst_n, .single_chip, .cpu_acc_valid, .cpu_acc_fetch, .cpu_acc_addr,
		.cpu_acc_size, .cpu_acc_periph, .cpu_acc_external, .dma_acc_valid, .dma_acc_addr,
		.dma_acc_size, .dma_acc_periph, .dma_acc_external, .insn_done, .next_pc, .status_word_in,
		.stack_gpr_in, .exc_req, .exc_src, .exc_vec, .vbr_in, .mem_req, .mem_we, .mem_addr,
		.mem_wdata, .mem_rdata, .mem_ack, .cpu_hold, .periph_reset, .load_pc, .new_pc, .load_sp,
		.new_sp, .load_vbr, .new_vbr, .load_sr, .new_sr, .cpu_aerr_seen, .dma_aerr_seen);
	exv_mem_model mem_u (.clk, .rst_n, .lat, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata,
		.mem_ack);

	// 40 MHz clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// Verdict and end of run
	task automatic stop_test();
		$display("Checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : stop_test

	// Hold the clear pin low n cycles, then release
	task automatic do_reset(input int n);
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (n - 1) @(posedge clk);
		@(negedge clk);
		`CHK("reset hold", 3'h7, {periph_reset, cpu_hold, ~mem_req})
		@(posedge clk);
		rst_n <= 1'b1;
	endtask : do_reset

	// Wait for the PC load pulse, bounded
	task automatic wait_load();
		for (int i = 0; i < 60 && load_pc !== 1'b1; i++) @(negedge clk);
		`CHK("load_pc", 1'b1, load_pc)
	endtask : wait_load

	// Reset entry with its loads
	task automatic t_reset(input int n);
		do_reset(n);
		wait_load();
		`CHK("reset pc", 32'ha500_0000, new_pc)
		`CHK("reset sp", 32'ha500_0004, new_sp)
		`CHK("reset base", 33'h1_0000_0000, {load_vbr, new_vbr})
		`CHK("reset mask", 5'h1f, {load_sr, new_sr[7:4]})
		@(negedge clk);
		`CHK("running", 1'b0, cpu_hold)
	endtask : t_reset

	// Present one access and judge its error flag
	task automatic probe(input logic d, f, input logic [31:0] a, input logic [1:0] s,
		input logic p, x, e);
		@(posedge clk);
		cpu_acc_valid <= !d;
		dma_acc_valid <= d;
		cpu_acc_fetch <= f;
		cpu_acc_addr <= a;
		dma_acc_addr <= a;
		cpu_acc_size <= s;
		dma_acc_size <= s;
		cpu_acc_periph <= p;
		dma_acc_periph <= p;
		cpu_acc_external <= x;
		dma_acc_external <= x;
		@(negedge clk);
		`CHK("error flag", e, d ? dma_aerr_seen : cpu_aerr_seen)
		// One-cycle access, so it is detected once
		@(posedge clk);
		cpu_acc_valid <= 1'b0;
		dma_acc_valid <= 1'b0;
	endtask : probe

	// End an instruction and judge the entry that follows
	task automatic entry(input logic [7:0] vec, input logic [31:0] pc);
		@(posedge clk);
		insn_done <= 1'b1;
		next_pc <= pc;
		@(posedge clk);
		insn_done <= 1'b0;
		exc_req <= 1'b0;
		cpu_acc_valid <= 1'b0;
		dma_acc_valid <= 1'b0;
		wait_load();
		`CHK("push sr", {32'h7ffc, 32'h30}, {mem_u.wa[0], mem_u.wd[0]})
		`CHK("push pc", {32'h7ff8, pc}, {mem_u.wa[1], mem_u.wd[1]})
		`CHK("handler", 32'ha500_1000 ^ {22'h0, vec, 2'h0}, new_pc)
		`CHK("sp", {2'h1, 32'h7ff8}, {load_sr, load_sp, new_sp})
	endtask : entry

	// Request one other exception
	task automatic t_req(input exv_src_e s, input logic [7:0] v, input logic [7:0] ex);
		@(posedge clk);
		exc_req <= 1'b1;
		exc_src <= s;
		exc_vec <= v;
		entry(ex, 32'h6000);
	endtask : t_req

	// Odd fetch detected in the very cycle the instruction ends
	task automatic t_same();
		fork
			entry(EXV_VEC_CPU_AERR, 32'h2502);
			begin
				@(posedge clk);
				cpu_acc_valid <= 1'b1;
				cpu_acc_fetch <= 1'b1;
				cpu_acc_addr <= 32'h2501;
				cpu_acc_periph <= 1'b0;
				cpu_acc_external <= 1'b0;
			end
		join
	endtask : t_same

	// Hang guard
	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		stop_test();
	end

	// Main sequence
	initial begin
		{rst_n, insn_done, exc_req, cpu_acc_valid, dma_acc_valid, single_chip} = 6'h1;
		{cpu_acc_fetch, cpu_acc_periph, cpu_acc_external, dma_acc_periph, dma_acc_external} = 5'h0;
		{cpu_acc_addr, dma_acc_addr, next_pc, cpu_acc_size, dma_acc_size, exc_vec} = '0;
		exc_src = EXV_SRC_NMI;
		status_word_in = 32'h30;
		stack_gpr_in = 32'h8000;
		vbr_in = 32'h1000;
		lat = 4'h3;
		t_reset(4);
		lat <= 4'h0;
		probe(0, 1, 32'h2000, EXV_SZ_WORD, 0, 0, 0);
		probe(0, 1, 32'h2001, EXV_SZ_WORD, 0, 0, 1);
		repeat (3) @(negedge clk);
		`CHK("deferred", 1'b0, mem_req)
		entry(EXV_VEC_CPU_AERR, 32'h2002);
		probe(0, 1, 32'h4000, EXV_SZ_LONG, 1, 0, 1);
		entry(EXV_VEC_CPU_AERR, 32'h2102);
		probe(1, 0, 32'h3004, EXV_SZ_LONG, 0, 0, 0);
		probe(1, 0, 32'h3002, EXV_SZ_LONG, 0, 0, 1);
		entry(EXV_VEC_DMA_AERR, 32'h2204);
		probe(1, 0, 32'h3002, EXV_SZ_WORD, 0, 0, 0);
		probe(1, 0, 32'h3001, EXV_SZ_WORD, 0, 0, 1);
		lat <= 4'h2;
		entry(EXV_VEC_DMA_AERR, 32'h2306);
		probe(1, 0, 32'h5003, EXV_SZ_LONG, 1, 0, 0);
		probe(0, 0, 32'h5001, EXV_SZ_WORD, 1, 0, 0);
		single_chip <= 1'b0;
		probe(0, 0, 32'h8000_0000, EXV_SZ_BYTE, 0, 1, 0);
		single_chip <= 1'b1;
		probe(0, 0, 32'h8000_0000, EXV_SZ_BYTE, 0, 1, 1);
		entry(EXV_VEC_CPU_AERR, 32'h2408);
		t_same();
		t_req(EXV_SRC_NMI, 8'h0, EXV_VEC_NMI);
		t_req(EXV_SRC_UBRK, 8'h0, EXV_VEC_UBRK);
		t_req(EXV_SRC_GEN_ILL, 8'h0, EXV_VEC_GEN_ILL);
		t_req(EXV_SRC_SLOT_ILL, 8'h0, EXV_VEC_SLOT_ILL);
		t_req(EXV_SRC_TRAP, 8'h00, 8'h20);
		t_req(EXV_SRC_TRAP, 8'h1f, 8'h3f);
		t_req(EXV_SRC_IRQ, 8'h40, 8'h40);
		t_reset(40);
		stop_test();
	end
endmodule : test_cpu_exception_vectoring_reset_addr_err
